// ==== rtl/cdu_consts.vh ====
// Constants for the current DAC update control block.
// Included by the design files by bare name; definitions only.
`ifndef CDU_CONSTS_VH
`define CDU_CONSTS_VH
// Register byte offsets, one aligned word each
`define CDU_OFF_CTRL0      8'h00
`define CDU_OFF_LOW0       8'h04
`define CDU_OFF_HIGH0      8'h08
`define CDU_OFF_CTRL1      8'h10
`define CDU_OFF_LOW1       8'h14
`define CDU_OFF_HIGH1      8'h18
`define CDU_OFF_STATUS     8'h20
// Control register fields
`define CDU_EN_BIT         7
`define CDU_MODE_HI        6
`define CDU_MODE_LO        4
`define CDU_RANGE_HI       1
`define CDU_RANGE_LO       0
// Update modes
`define CDU_MODE_TMR0      3'h0
`define CDU_MODE_TMR1      3'h1
`define CDU_MODE_TMR2      3'h2
`define CDU_MODE_TMR3      3'h3
`define CDU_MODE_RISE      3'h4
`define CDU_MODE_FALL      3'h5
`define CDU_MODE_ANYEDGE   3'h6
`define CDU_MODE_DEMAND    3'h7
// Full-scale range codes: 0.5 mA, 1 mA, 2 mA
`define CDU_RANGE_0P5MA    2'h0
`define CDU_RANGE_1MA      2'h1
`define CDU_RANGE_2MA      2'h2
// Reset values and bus response codes
`define CDU_CTRL_RESET     8'h70
`define CDU_RESP_OKAY      2'h0
`define CDU_RESP_SLVERR    2'h2
`endif

// ==== rtl/cdu_channel.v ====
// One converter channel: staging, trigger select and output latch.
// Assumes single clock; triggers and pin level synchronous to aclk.
`include "cdu_consts.vh"
module cdu_channel #(
   parameter CODE_W = 10
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [7:0]        ctrl,
   input  wire              wr_high,
   input  wire              wr_low,
   input  wire [7:0]        wdata,
   input  wire [3:0]        timer_ovf,
   input  wire              trig_pin,
   output reg  [CODE_W-1:0] code,
   output reg  [CODE_W-1:0] staged
);
   reg  [2:0] mode;
   reg        pin_q;
   reg        fire;
   always @* begin
      mode = ctrl[`CDU_MODE_HI:`CDU_MODE_LO];
      case (mode)
         `CDU_MODE_TMR0:    fire = timer_ovf[0];
         `CDU_MODE_TMR1:    fire = timer_ovf[1];
         `CDU_MODE_TMR2:    fire = timer_ovf[2];
         `CDU_MODE_TMR3:    fire = timer_ovf[3];
         `CDU_MODE_RISE:    fire = trig_pin & ~pin_q;
         `CDU_MODE_FALL:    fire = ~trig_pin & pin_q;
         `CDU_MODE_ANYEDGE: fire = trig_pin ^ pin_q;
         default:           fire = wr_high;
      endcase
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_q  <= 1'b0;
         code   <= {CODE_W{1'b0}};
         staged <= {CODE_W{1'b0}};
      end else begin
         pin_q <= trig_pin;
         // Low byte holds only bits [1:0] in its top two positions
         if (wr_low)
            staged[1:0] <= wdata[7:6];
         if (wr_high)
            staged[CODE_W-1:2] <= wdata;
         // Latch takes the high byte being written this cycle
         if (fire && ctrl[`CDU_EN_BIT]) begin
            if (wr_high)
               code <= {wdata, (wr_low ? wdata[7:6] : staged[1:0])};
            else
               code <= staged;
         end
      end
   end
endmodule // cdu_channel

// ==== rtl/cdu_top.v ====
// Two current DAC update controllers behind an AXI4-Lite slave.
// Assumes one 25 MHz clock, synchronous trigger inputs and pad logic outside.
// Operation
// - Two independent converters, each taking a 10-bit code.
// - Each converter selects 0.5, 1 or 2 mA full-scale range.
// - Enable clear leaves the pin as ordinary GPIO.
// - Enable set disables pin driver and pull-up, connects converter output.
// - Bias generator runs while any converter is enabled.
// - Updates trigger on high-byte write, timer overflow or pin edge.
// - Mode field bits 6:4 reset to 111, on-demand mode.
// - On-demand: low-byte writes held until high byte written.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "cdu_consts.vh"
module cdu_top #(
   parameter CODE_W = 10
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire [7:0]        s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [7:0]        s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire [3:0]        timer_ovf,
   input  wire [1:0]        trig_pin,
   output reg  [CODE_W-1:0] dac0_code,
   output reg  [CODE_W-1:0] dac1_code,
   output reg  [1:0]        dac0_range,
   output reg  [1:0]        dac1_range,
   output reg  [1:0]        dac_pin_connect,
   output reg  [1:0]        gpio_driver_disable,
   output reg  [1:0]        gpio_pullup_disable,
   output reg               bias_enable
);
   reg  [7:0]        ctrl [0:1];
   reg  [7:0]        aw_addr;
   reg  [31:0]       w_data;
   reg  [3:0]        w_strb;
   reg               aw_have;
   reg               w_have;
   wire [CODE_W-1:0] code   [0:1];
   wire [CODE_W-1:0] staged [0:1];
   wire              do_wr;
   wire              lane0;
   wire [1:0]        wr_low_v;
   wire [1:0]        wr_high_v;
   reg               wr_ok;
   reg  [31:0]       rd_val;
   reg               rd_ok;

   // Write fires once both address and data have been caught
   assign do_wr = aw_have && w_have && !s_axi_bvalid;
   assign lane0 = w_strb[0];

   // Per converter: its control register and its update channel
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
         assign wr_low_v[gi]  = do_wr && lane0 && (aw_addr == (`CDU_OFF_LOW0 + gi*8'h10));
         assign wr_high_v[gi] = do_wr && lane0 && (aw_addr == (`CDU_OFF_HIGH0 + gi*8'h10));
         cdu_channel #(.CODE_W(CODE_W)) u_ch (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .ctrl      (ctrl[gi]),
            .wr_high   (wr_high_v[gi]),
            .wr_low    (wr_low_v[gi]),
            .wdata     (w_data[7:0]),
            .timer_ovf (timer_ovf),
            .trig_pin  (trig_pin[gi]),
            .code      (code[gi]),
            .staged    (staged[gi])
         );
         always @(posedge aclk) begin
            if (!aresetn) begin
               ctrl[gi] <= `CDU_CTRL_RESET;
            end else if (do_wr && lane0 && aw_addr == (`CDU_OFF_CTRL0 + gi*8'h10)) begin
               ctrl[gi] <= w_data[7:0];
            end
         end
      end
   endgenerate

   // Writes to unmapped offsets get an error response and store nothing
   always @* begin
      case (aw_addr)
         `CDU_OFF_CTRL0, `CDU_OFF_LOW0, `CDU_OFF_HIGH0,
         `CDU_OFF_CTRL1, `CDU_OFF_LOW1, `CDU_OFF_HIGH1: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Data offsets read back the staged bytes, not what the converter shows
   always @* begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `CDU_OFF_CTRL0:  rd_val = {24'h000000, ctrl[0]};
         `CDU_OFF_LOW0:   rd_val = {24'h000000, staged[0][1:0], 6'h00};
         `CDU_OFF_HIGH0:  rd_val = {24'h000000, staged[0][CODE_W-1:2]};
         `CDU_OFF_CTRL1:  rd_val = {24'h000000, ctrl[1]};
         `CDU_OFF_LOW1:   rd_val = {24'h000000, staged[1][1:0], 6'h00};
         `CDU_OFF_HIGH1:  rd_val = {24'h000000, staged[1][CODE_W-1:2]};
         `CDU_OFF_STATUS: rd_val = {12'h000, code[1], code[0]};
         default: begin
            rd_val = 32'h00000000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   // Write address: ready is a one-cycle pulse, address kept until the response
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_have       <= 1'b0;
         aw_addr       <= 8'h00;
      end else begin
         s_axi_awready <= s_axi_awvalid && !aw_have && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have <= 1'b0;
         end
      end
   end

   // Write data: may arrive before or after the address
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_have       <= 1'b0;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
      end else begin
         s_axi_wready <= s_axi_wvalid && !w_have && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (s_axi_bvalid && s_axi_bready) begin
            w_have <= 1'b0;
         end
      end
   end

   // Write response follows both halves; the captured halves are freed
   // only at its handshake, so a second write cannot overtake the first
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CDU_RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `CDU_RESP_OKAY : `CDU_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read address: refused while read data still stands,
   // so at most one read is ever under way
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      end
   end

   // Read data: decoded from s_axi_araddr as presented at the handshake edge
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `CDU_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_ok ? `CDU_RESP_OKAY : `CDU_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Pin ownership and analog controls, all registered
   always @(posedge aclk) begin
      if (!aresetn) begin
         dac0_code           <= {CODE_W{1'b0}};
         dac1_code           <= {CODE_W{1'b0}};
         dac0_range          <= `CDU_RANGE_0P5MA;
         dac1_range          <= `CDU_RANGE_0P5MA;
         dac_pin_connect     <= 2'b00;
         gpio_driver_disable <= 2'b00;
         gpio_pullup_disable <= 2'b00;
         bias_enable         <= 1'b0;
      end else begin
         dac0_code  <= code[0];
         dac1_code  <= code[1];
         // Reserved code 3 falls back to the 2 mA setting
         dac0_range <= (ctrl[0][1:0] == 2'h3) ? `CDU_RANGE_2MA : ctrl[0][1:0];
         dac1_range <= (ctrl[1][1:0] == 2'h3) ? `CDU_RANGE_2MA : ctrl[1][1:0];
         dac_pin_connect     <= {ctrl[1][`CDU_EN_BIT], ctrl[0][`CDU_EN_BIT]};
         gpio_driver_disable <= {ctrl[1][`CDU_EN_BIT], ctrl[0][`CDU_EN_BIT]};
         gpio_pullup_disable <= {ctrl[1][`CDU_EN_BIT], ctrl[0][`CDU_EN_BIT]};
         bias_enable <= ctrl[0][`CDU_EN_BIT] | ctrl[1][`CDU_EN_BIT];
      end
   end
endmodule // cdu_top

// ==== tb/cdu_checker.sv ====
// Checker for cdu_top: bus handshakes, pin hand-over and held codes.
// Assumes it is bound to cdu_top and sees that module's ports only.
module cdu_checker #(
   parameter CODE_W = 10
) (
   input wire              aclk,
   input wire              aresetn,
   input wire              s_axi_awready,
   input wire              s_axi_wready,
   input wire              s_axi_bvalid,
   input wire              s_axi_bready,
   input wire              s_axi_arvalid,
   input wire              s_axi_arready,
   input wire              s_axi_rvalid,
   input wire              s_axi_rready,
   input wire [31:0]       s_axi_rdata,
   input wire [CODE_W-1:0] dac0_code,
   input wire [CODE_W-1:0] dac1_code,
   input wire [1:0]        dac_pin_connect,
   input wire [1:0]        gpio_driver_disable,
   input wire [1:0]        gpio_pullup_disable,
   input wire              bias_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bias_any: assert property (bias_enable == |dac_pin_connect)
      else $error("bias not the OR of enables");
   a_driver_off: assert property (gpio_driver_disable == dac_pin_connect)
      else $error("driver disable differs from enable");
   a_pullup_off: assert property (gpio_pullup_disable == dac_pin_connect)
      else $error("pull-up disable differs from enable");
   a_code0_held: assert property (!dac_pin_connect[0] [*2] |=> $stable(dac0_code))
      else $error("dac0 code moved while disabled");
   a_code1_held: assert property (!dac_pin_connect[1] [*2] |=> $stable(dac1_code))
      else $error("dac1 code moved while disabled");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
                                  s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed early");
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   cover property ($rose(bias_enable));
   cover property ($changed(dac1_code));
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule // cdu_checker

bind cdu_top cdu_checker #(.CODE_W(CODE_W)) chk_u (.*);

// ==== tb/cdu_top_tb.sv ====
// Bench for cdu_top: register access, update modes and pin hand-over.
// Assumes cdu_top with the checker bound; one 25 MHz clock.
`include "cdu_consts.vh"
module cdu_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, bias_enable;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb, timer_ovf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, trig_pin, dac0_range, dac1_range, rs;
   logic [1:0]  dac_pin_connect, gpio_driver_disable, gpio_pullup_disable;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [9:0]  dac0_code, dac1_code, e1;
   int          miscompares = 0;
   int          n_checks = 0;
   int          m;
   logic [6:0]  pins;
   cdu_top #(.CODE_W(10)) dut_u (.*);
   assign pins = {bias_enable, dac_pin_connect, gpio_driver_disable, gpio_pullup_disable};
   task results;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task hang;
      miscompares++;
      results;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Late bready on purpose, so the slave must hold its response
      for (i = 0; i < 50 && !(s_axi_bvalid && s_axi_bready); i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (i == 50) hang;
      tick(2);
   endtask
   task rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (i == 50) hang;
   endtask
   task pulse(input logic [3:0] t, input logic f);
      @(posedge aclk);
      timer_ovf <= t;
      trig_pin[1] <= trig_pin[1] ^ f;
      @(posedge aclk);
      timer_ovf <= 4'h0;
      tick(3);
   endtask
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, timer_ovf, trig_pin} = 54'h0;
      s_axi_wstrb = 4'h1;
      e1 = 10'h000;
      tick(8);
      aresetn <= 1'b1;
      rd(`CDU_OFF_CTRL0);
      chk(rv, 32'h00000070);
      rd(`CDU_OFF_CTRL1);
      chk(rv, 32'h00000070);
      // Range code 3 is reserved and falls back to 2 mA
      for (m = 0; m < 4; m++) begin
         wr(`CDU_OFF_CTRL0, {6'h3c, m[1:0]});
         chk(rs, `CDU_RESP_OKAY);
         chk(dac0_range, (m == 3) ? `CDU_RANGE_2MA : m[1:0]);
      end
      chk(pins, 7'h55);
      wr(`CDU_OFF_LOW0, 8'hc0);
      chk(dac0_code, 10'h000);
      wr(`CDU_OFF_HIGH0, 8'ha5);
      chk(dac0_code, 10'h297);
      wr(`CDU_OFF_HIGH0, 8'h12);
      chk(dac0_code, 10'h04b);
      rd(`CDU_OFF_STATUS);
      chk(rv, 32'h0000004b);
      wr(`CDU_OFF_CTRL1, 8'h82);
      wr(`CDU_OFF_LOW1, 8'h40);
      // Each timer and pin trigger mode (not on-demand): wrong events first, then the selected one
      for (m = 0; m < 7; m++) begin
         wr(`CDU_OFF_CTRL1, {1'b1, m[2:0], 4'h2});
         wr(`CDU_OFF_HIGH1, 8'(m + 1));
         chk(dac1_code, e1);
         pulse(m < 4 ? 4'hf ^ (4'h1 << m) : 4'hf, 1'b0);
         chk(dac1_code, e1);
         pulse(m < 4 ? 4'h1 << m : 4'h0, m >= 4);
         e1 = {8'(m + 1), 2'b01};
         chk(dac1_code, e1);
      end
      chk(dac1_range, `CDU_RANGE_2MA);
      wr(`CDU_OFF_CTRL0, 8'h72);
      wr(`CDU_OFF_HIGH0, 8'hff);
      chk(dac0_code, 10'h04b);
      chk(pins, 7'h6a);
      wr(`CDU_OFF_CTRL1, 8'h00);
      chk(pins, 7'h00);
      rd(8'h3c);
      chk(rs, `CDU_RESP_SLVERR);
      chk(rv, 32'h00000000);
      wr(8'h3c, 8'h55);
      chk(rs, `CDU_RESP_SLVERR);
      results;
   end
endmodule // cdu_top_tb
